// ===== logic/adc_clock_and_power_sequencer.sv
`include "adc_seq_cfg.svh"

// Contract
// - With the CPU clock selected a conversion ends after 31 machine cycles.
// - Setting rc_clock_select runs the converter from the RC oscillator ticks.
// - RC mode first spends 3 to 4 machine cycles syncing, then 108 RC clocks.
// - Completion while the CPU idles wakes it when the interrupt is enabled.
// - In RC mode a conversion runs on to completion during Power Down.
// - Power Down in CPU-clock mode aborts the conversion without a wake-up.
// - Completion sets the done flag and loads the result; software clears.
// - Start begins a conversion, stays set while busy, starts are ignored.
module adc_clock_and_power_sequencer #(
  parameter int MC_DIV = `MC_DIV_DEFAULT
) (
  input wire logic ref_clk, // CPU clock, 40 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [1:0] addr, // Register address
  input wire logic [7:0] wdata, // Register write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic rc_tick, // One pulse per RC oscillator clock
  input wire logic cpu_idle, // CPU in Idle
  input wire logic cpu_power_down, // CPU in Power Down
  input wire logic comp_high, // SAR comparator: input above DAC
  output logic [7:0] rdata, // Read data, cycle after rd
  output logic [1:0] channel_sel, // Analog input select
  output logic sample_hold, // Sampling phase active
  output logic [7:0] sar_dac, // Trial code to the DAC
  output logic wake_cpu, // One-cycle wake pulse to the core
  output logic irq // Level interrupt
);

  // Machine-cycle enable from the divider
  logic mc_tick;
  adc_seq_pkg::seq_state_t state_reg;
  adc_seq_pkg::seq_state_t state_next;
  adc_seq_pkg::ctrl_t ctrl_reg;
  adc_seq_pkg::ctrl_t ctrl_next;
  adc_seq_pkg::irq_bits_t status_reg;
  adc_seq_pkg::irq_bits_t status_next;
  adc_seq_pkg::irq_bits_t mask_reg;
  adc_seq_pkg::irq_bits_t mask_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [7:0] sar_reg;
  logic [7:0] sar_next;
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic [7:0] rdata_next;
  logic sample_next;
  logic wake_next;
  logic irq_next;

  // Decode shared by the sequencer and the register file
  logic conv_tick;
  logic [6:0] conv_len;
  logic [6:0] sar_from;
  logic start_req;
  logic finish;
  logic abort;

  // Bit k of a byte as a one-hot mask
  function automatic logic [7:0] bit_mask(input logic [2:0] k);
    bit_mask = 8'h01 << k;
  endfunction : bit_mask

  // Shared by CPU-mode timing and the sync count
  mc_tick_gen #(
    .DIV(MC_DIV)
  ) u_mc_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(mc_tick)
  );

  // Conversion time base depends on the clock source
  // RC ticks arrive already aligned to the CPU clock
  always_comb
  begin
    conv_tick = ctrl_reg.rc_sel ? rc_tick : mc_tick;
    conv_len = ctrl_reg.rc_sel ? `RC_CONV_CLKS : `CPU_CONV_MC;
    sar_from = conv_len - `SAR_STEPS;
  end

  // Starts only count while neither busy nor done is set
  assign start_req = wr && (addr == `OFS_CONTROL) && wdata[`CTL_START]
    && !ctrl_reg.start_busy && !ctrl_reg.done;

  // Only the CPU-clock mode loses its clock in Power Down
  assign abort = cpu_power_down && !ctrl_reg.rc_sel
    && (state_reg != adc_seq_pkg::ST_IDLE);

  // Last tick of the count; an abort in the same cycle wins
  assign finish = (state_reg == adc_seq_pkg::ST_CONV) && !abort
    && conv_tick && (cnt_reg == conv_len - 7'd1);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    sync_next = sync_reg;
    sar_next = sar_reg;
    result_next = result_reg;
    sample_next = 1'b0;
    unique case (state_reg)
      adc_seq_pkg::ST_IDLE:
      begin
        if (start_req)
        begin
          // Counters restart on every accepted start
          cnt_next = 7'd0;
          sync_next = 2'd0;
          sar_next = `SAR_FIRST;
          // Sync spans the partial start cycle plus three whole ones
          if (wdata[`CTL_RC_SEL])
            state_next = adc_seq_pkg::ST_SYNC;
          else
            state_next = adc_seq_pkg::ST_CONV;
        end
      end
      adc_seq_pkg::ST_SYNC:
      begin
        if (mc_tick)
        begin
          sync_next = sync_reg + 2'd1;
          // Fourth boundary ends it: 3 to 4 machine cycles in all
          if (sync_reg == `SYNC_MC)
            state_next = adc_seq_pkg::ST_CONV;
        end
      end
      adc_seq_pkg::ST_CONV:
      begin
        // DAC rests at midscale while the input is sampled
        sample_next = (cnt_reg < sar_from);
        if (conv_tick)
        begin
          if (cnt_reg >= sar_from)
          begin
            // Keep trial bit if input is above, then try the next one
            if (!comp_high)
              sar_next = sar_reg
                & ~bit_mask(3'(conv_len - 7'd1 - cnt_reg));
            if (cnt_reg != conv_len - 7'd1)
              sar_next = sar_next
                | bit_mask(3'(conv_len - 7'd2 - cnt_reg));
          end
          if (finish)
          begin
            state_next = adc_seq_pkg::ST_IDLE;
            result_next = sar_next;
            sample_next = 1'b0;
          end
          else
          begin
            cnt_next = cnt_reg + 7'd1;
          end
        end
      end
    endcase
    if (abort)
    begin
      // Result keeps the previous conversion; only sar_reg is left holding partial bits
      state_next = adc_seq_pkg::ST_IDLE;
      sample_next = 1'b0;
    end
  end

  // Result only loads at completion, so an abort leaves it stale
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= adc_seq_pkg::ST_IDLE;
      cnt_reg <= 7'd0;
      sync_reg <= 2'd0;
      sar_reg <= `SAR_FIRST;
      result_reg <= `RESULT_RST;
      sample_hold <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sync_reg <= sync_next;
      sar_reg <= sar_next;
      result_reg <= result_next;
      sample_hold <= sample_next;
    end
  end

  // Register file, flags and interrupt
  always_comb
  begin
    ctrl_next = ctrl_reg;
    status_next = status_reg;
    mask_next = mask_reg;
    rdata_next = 8'h00;
    // Writes to the result register fall through and are dropped
    if (wr)
    begin
      unique case (addr)
        `OFS_CONTROL:
        begin
          // Clock source is frozen while busy or done; channel is frozen while busy, and while done a write can only clear its bits
          if (!ctrl_reg.start_busy && !ctrl_reg.done)
          begin
            ctrl_next.channel = wdata[`CTL_CHAN_HI:`CTL_CHAN_LO];
            ctrl_next.rc_sel = wdata[`CTL_RC_SEL];
          end
          else if (!ctrl_reg.start_busy)
            ctrl_next.channel = wdata[`CTL_CHAN_HI:`CTL_CHAN_LO] &
              ctrl_reg.channel;
          // Done clears on a zero write; a one leaves it alone
          if (!wdata[`CTL_DONE])
            ctrl_next.done = 1'b0;
          if (start_req)
            ctrl_next.start_busy = 1'b1;
        end
        `OFS_IRQ_STATUS:
        begin
          if (wdata[`IRQ_DONE])
            status_next.done = 1'b0;
          if (wdata[`IRQ_ABORT])
            status_next.abort = 1'b0;
        end
        `OFS_IRQ_MASK:
        begin
          mask_next.done = wdata[`IRQ_DONE];
          mask_next.abort = wdata[`IRQ_ABORT];
        end
        default:
        begin
        end
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (finish)
    begin
      ctrl_next.start_busy = 1'b0;
      ctrl_next.done = 1'b1;
      status_next.done = 1'b1;
    end
    if (abort)
    begin
      ctrl_next.start_busy = 1'b0;
      status_next.abort = 1'b1;
    end
    // Read data is registered; idle cycles return zero
    if (rd)
    begin
      unique case (addr)
        `OFS_CONTROL:
          rdata_next = {3'h0, ctrl_reg.done, ctrl_reg.start_busy,
            ctrl_reg.rc_sel, ctrl_reg.channel};
        `OFS_RESULT:
          rdata_next = result_reg;
        `OFS_IRQ_STATUS:
          rdata_next = {6'h00, status_reg};
        `OFS_IRQ_MASK:
          rdata_next = {6'h00, mask_reg};
        default:
          rdata_next = 8'h00;
      endcase
    end
    // Next values keep irq in step with the flag it reflects
    irq_next = |(status_next & mask_next);
    // Abort never wakes; completion wakes only with interrupt active
    wake_next = finish && mask_reg.done
      && (cpu_idle || cpu_power_down);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      // Control image is the low five bits of the byte
      ctrl_reg <= adc_seq_pkg::ctrl_t'(5'(`CONTROL_RST));
      status_reg <= `IRQ_STATUS_RST;
      mask_reg <= `IRQ_MASK_RST;
      rdata <= 8'h00;
      irq <= 1'b0;
      wake_cpu <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata <= rdata_next;
      irq <= irq_next;
      wake_cpu <= wake_next;
    end
  end

  // Both are flop values wired straight out
  assign channel_sel = ctrl_reg.channel;
  assign sar_dac = sar_reg;

endmodule : adc_clock_and_power_sequencer

// ===== logic/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// Register offsets on the plain register port
`define OFS_CONTROL 2'h0
`define OFS_RESULT 2'h1
`define OFS_IRQ_STATUS 2'h2
`define OFS_IRQ_MASK 2'h3

// Field positions in the converter control register
`define CTL_CHAN_LO 0
`define CTL_CHAN_HI 1
`define CTL_RC_SEL 2
`define CTL_START 3
`define CTL_DONE 4

// Field positions in the interrupt status and mask registers
`define IRQ_DONE 0
`define IRQ_ABORT 1

// Reset values
`define CONTROL_RST 8'h00
`define RESULT_RST 8'h00
`define IRQ_MASK_RST 2'h0
`define IRQ_STATUS_RST 2'h0
`define SAR_FIRST 8'h80

// Timing counts
`define CPU_CONV_MC 7'd31
`define RC_CONV_CLKS 7'd108
`define SYNC_MC 2'd3
`define SAR_STEPS 7'd8
`define MC_DIV_DEFAULT 6

`endif

// ===== logic/adc_seq_pkg.sv
package adc_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SYNC = 3'b010,
    ST_CONV = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic done;
    logic start_busy;
    logic rc_sel;
    logic [1:0] channel;
  } ctrl_t;

  typedef struct packed {
    logic abort;
    logic done;
  } irq_bits_t;

endpackage : adc_seq_pkg

// ===== logic/mc_tick_gen.sv
module mc_tick_gen #(
  parameter int DIV = 6
) (
  input wire logic ref_clk, // CPU clock
  input wire logic rst, // Synchronous reset, active high
  output logic tick // One-cycle pulse per machine cycle
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic tick_next;

  always_comb
  begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 8'h01;
    if (cnt_reg == 8'(DIV - 1))
    begin
      cnt_next = 8'h00;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_reg <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end

endmodule : mc_tick_gen

// ===== verif/adc_clock_and_power_sequencer_tb.sv
module adc_clock_and_power_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst = 1, wr = 0, rd = 0, idl = 0, pd = 0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, level = 8'h5A, rdata, sar_dac;
  logic [1:0] channel_sel;
  logic sample_hold, wake_cpu, irq, rc_tick, comp_high;
  int bad_count = 0, compares = 0, wakes = 0, cyc = 0, t0, n;
  logic [17:0] rows [7] = '{{2'h1, 8'hFF, 8'h00}, {2'h2, 8'h03, 8'h00},
    {2'h0, 8'h02, 8'h02}, {2'h0, 8'h06, 8'h06}, {2'h0, 8'hF1, 8'h01},
    {2'h0, 8'h00, 8'h00}, {2'h3, 8'h03, 8'h03}};

  adc_clock_and_power_sequencer #(.MC_DIV(6))
    adc_clock_and_power_sequencer_i (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rc_tick(rc_tick),
    .cpu_idle(idl), .cpu_power_down(pd), .comp_high(comp_high),
    .rdata(rdata), .channel_sel(channel_sel), .sample_hold(sample_hold),
    .sar_dac(sar_dac), .wake_cpu(wake_cpu), .irq(irq));
  analog_side_model analog_side_model_i (.ref_clk(ref_clk), .rst(rst),
    .sar_dac(sar_dac), .level(level), .rc_tick(rc_tick),
    .comp_high(comp_high));

  initial forever #12.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) wakes <= wakes + int'(wake_cpu === 1'b1);
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      test_done;
    end
  end

  task chk(input logic [7:0] s, e, input string nm);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task test_done;
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [1:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, e, nm);
  endtask : rd_chk

  // Low power entered one cycle before the start write
  task start(input logic [7:0] cw, input logic i, p);
    @(posedge ref_clk);
    idl <= i;
    pd <= p;
    wr_reg(2'h0, cw);
    #1 t0 = cyc;
  endtask : start

  task wait_irq;
    while (irq !== 1'b1 && cyc - t0 < 900)
      @(posedge ref_clk) #1;
    n = cyc - t0;
  endtask : wait_irq

  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1 chk(sar_dac, 8'h80, "dac rst");
    chk({7'h0, irq}, 8'h00, "irq rst");
    @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(rows[i][17:16], rows[i][15:8]);
      rd_chk(rows[i][17:16], rows[i][7:0], "reg row");
    end
    start(8'h09, 1'b1, 1'b0);
    @(posedge ref_clk) #1 chk({6'h0, channel_sel}, 8'h01, "chan");
    chk({7'h0, sample_hold}, 8'h01, "sampling");
    wait_irq;
    chk(8'(n >= 180 && n <= 188), 8'h01, "cpu time");
    chk({7'h0, sample_hold}, 8'h00, "sample end");
    rd_chk(2'h1, 8'h5A, "result");
    rd_chk(2'h0, 8'h11, "ctrl done");
    chk(8'(wakes), 8'h01, "idle wake");
    wr_reg(2'h0, 8'h19);
    rd_chk(2'h0, 8'h11, "start ignored");
    wr_reg(2'h2, 8'h03);
    wr_reg(2'h0, 8'h00);
    rd_chk(2'h0, 8'h00, "ctrl clr");
    chk({7'h0, irq}, 8'h00, "irq clr");
    level = 8'hA5;
    start(8'h0C, 1'b0, 1'b1);
    rd_chk(2'h0, 8'h0C, "busy");
    wr_reg(2'h0, 8'h0D);
    rd_chk(2'h0, 8'h0C, "busy hold");
    wait_irq;
    chk(8'(n >= 555 && n <= 564), 8'h01, "rc time");
    rd_chk(2'h1, 8'hA5, "pd result");
    chk(8'(wakes), 8'h02, "pd wake");
    wr_reg(2'h2, 8'h03);
    wr_reg(2'h0, 8'h00);
    wr_reg(2'h0, 8'h00);
    start(8'h08, 1'b0, 1'b0);
    repeat (20) @(posedge ref_clk);
    pd <= 1'b1;
    repeat (5) @(posedge ref_clk);
    pd <= 1'b0;
    rd_chk(2'h0, 8'h00, "abort ctrl");
    rd_chk(2'h2, 8'h02, "abort flag");
    chk(8'(wakes), 8'h02, "abort wake");
    wr_reg(2'h3, 8'h00);
    #1 chk({7'h0, irq}, 8'h00, "masked");
    wr_reg(2'h3, 8'h02);
    #1 chk({7'h0, irq}, 8'h01, "unmasked");
    wr_reg(2'h2, 8'h02);
    #1 chk({7'h0, irq}, 8'h00, "w1c");
    test_done;
  end
endmodule : adc_clock_and_power_sequencer_tb

// ===== verif/adc_seq_chk_sva.sv
module adc_seq_chk #(
  parameter int MC_DIV = 6
) (
  input wire logic ref_clk, // CPU clock
  input wire logic rst, // Sync reset
  input wire logic [1:0] addr, // Address
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic cpu_idle, // Idle
  input wire logic cpu_power_down, // Power Down
  input wire logic [7:0] rdata, // Read data
  input wire logic [1:0] channel_sel, // Channel
  input wire logic sample_hold, // Sampling
  input wire logic [7:0] sar_dac, // Trial code
  input wire logic wake_cpu, // Wake pulse
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata set without a read");
  a_wake_cause: assert property (wake_cpu |->
    $past(cpu_idle) || $past(cpu_power_down))
    else $error("wake while CPU running");
  a_wake_irq: assert property (wake_cpu |-> irq)
    else $error("wake without interrupt");
  a_wake_gap: assert property (wake_cpu |=> !wake_cpu [*8])
    else $error("wake not a single pulse");
  a_chan_write: assert property ($changed(channel_sel) |->
    $past(wr) && $past(addr) == 2'h0)
    else $error("channel moved without a write");
  a_irq_drop: assert property ($fell(irq) |->
    $past(wr) || $past(wr, 2))
    else $error("irq fell without a write");
  a_sample_dac: assert property (sample_hold |-> sar_dac == 8'h80)
    else $error("trial code not at midscale");
  a_sample_wake: assert property (sample_hold |-> !wake_cpu)
    else $error("wake during sampling");

  c_wake: cover property (wake_cpu);
  c_irq_clr: cover property ($fell(irq));
  c_sample: cover property ($rose(sample_hold));
endmodule : adc_seq_chk

bind adc_clock_and_power_sequencer adc_seq_chk #(.MC_DIV(MC_DIV))
  adc_seq_chk_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr(wr),
  .rd(rd), .cpu_idle(cpu_idle), .cpu_power_down(cpu_power_down),
  .rdata(rdata), .channel_sel(channel_sel), .sample_hold(sample_hold),
  .sar_dac(sar_dac), .wake_cpu(wake_cpu), .irq(irq));

// ===== verif/analog_side_model.sv
module analog_side_model #(
  parameter int RC_DIV = 5
) (
  input wire logic ref_clk, // CPU clock
  input wire logic rst, // Sync reset
  input wire logic [7:0] sar_dac, // Trial code
  input wire logic [7:0] level, // Input as a code
  output logic rc_tick, // RC clock pulse
  output logic comp_high // Input above trial
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // RC kept slower than the CPU clock
  always @(posedge ref_clk)
  begin
    cnt <= (rst || cnt == RC_DIV - 1) ? 0 : cnt + 1;
    rc_tick <= (cnt == RC_DIV - 1);
  end
  // Half a code above level, so ties resolve up
  assign comp_high = (sar_dac <= level);
endmodule : analog_side_model
